// ===== bench/hpps_queue_model.sv
// Sample queue and playback source on the far side of the sequencer.
// Assumes the same clock; stall holds back draining.
`timescale 1ns/1ns
module hpps_queue_model #(parameter int DEPTH = 4) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Queue side
  input  wire logic       queueWrite,
  input  wire logic [7:0] queueData,
  input  wire logic       stall,
  output logic            queueFull,
  output logic            sourceEmpty,
  output logic            sampleValid,
  output logic      [7:0] sampleIn
);
  int         fill, next_fill;
  logic       next_valid;
  logic [7:0] held, next_held;
  always_comb begin
    next_fill  = fill;
    next_held  = held;
    next_valid = 1'b0;
    if (queueWrite) begin
      next_fill = fill + 1;
      next_held = queueData;
    end else if (!stall && fill > 0) begin
      next_fill  = fill - 1;
      next_valid = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    fill        <= rst ? 0 : next_fill;
    held        <= next_held;
    sampleValid <= !rst && next_valid;
  end
  assign sampleIn    = sampleValid ? held : ~held;
  assign queueFull   = fill >= DEPTH;
  assign sourceEmpty = fill == 0;
endmodule : hpps_queue_model

// ===== bench/hpps_top_props.sv
// Checker for the haptic power sequencer ports.
// Assumes the shortened startup count is handed on by the bind.
`timescale 1ns/1ns
module hpps_top_props
  import hpps_pkg::*;
#(parameter int STARTUP_CNT = STARTUP_CYCLES) (
  // Clock, reset and register port
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  // Queue and playback
  input wire logic       queueWrite,
  input wire logic [7:0] queueData,
  input wire logic       queueNak,
  input wire logic       queueFull,
  input wire logic       playStart,
  // Power control and flags
  input wire logic       boostEnable,
  input wire logic       ampEnable,
  input wire logic [1:0] gainSelect,
  input wire logic       overTemp,
  input wire logic       brownout
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int onCnt, next_onCnt;
  always_comb next_onCnt = (boostEnable || overTemp) ? onCnt + 1 : 0;
  always_ff @(posedge clock) onCnt <= rst ? 0 : next_onCnt;
  a_start_delay: assert property (playStart |-> onCnt >= STARTUP_CNT - 2)
    else $error("playback began before startup");
  a_queue_accept: assert property (queueWrite |-> $past(regWrite) &&
    $past(regAddr) == OFS_QUEUE && !$past(queueFull)) else $error("bad queue write");
  a_data_follow: assert property (queueWrite |-> queueData == $past(regWdata))
    else $error("queue byte wrong");
  a_nak_cause: assert property (queueNak |-> $past(queueFull) && $past(regWrite))
    else $error("refusal without full queue");
  a_enables_pair: assert property (boostEnable == ampEnable)
    else $error("enables differ");
  a_hot_off: assert property (overTemp [*6] |-> !boostEnable)
    else $error("power on while hot");
  a_brown_reset: assert property (brownout [*8] |-> !boostEnable &&
    gainSelect == RST_GAIN) else $error("no reset on brownout");
  a_soft_reset: assert property (regWrite && regAddr == OFS_CTRL &&
    regWdata[CTRL_SOFTRST] |-> ##2 !ampEnable && gainSelect == RST_GAIN)
    else $error("soft reset ignored");
endmodule : hpps_top_props
bind hpps_top hpps_top_props #(.STARTUP_CNT(STARTUP_CNT)) i_props (.clock, .rst,
  .regAddr, .regWdata, .regWrite, .queueWrite, .queueData, .queueNak, .queueFull,
  .playStart, .boostEnable, .ampEnable, .gainSelect, .overTemp, .brownout);

// ===== bench/hpps_top_test.sv
// Testbench for the haptic power sequencer: register tasks and scenarios.
// Assumes the queue model on the far side and shortened timing.
`timescale 1ns/1ns
module hpps_top_test
  import hpps_pkg::*;
;
  localparam int SU = 20;
  logic       clock = 0, rst = 1, regWrite = 0, regRead = 0, stall = 1;
  logic       overTemp = 0, brownout = 0;
  logic [7:0] regAddr = 0, regWdata = 0, v;
  logic       queueWrite, queueNak, queueFull, sourceEmpty, playStart;
  logic       sampleValid, boostEnable, ampEnable, analogSelect;
  logic [7:0] regRdata, queueData, sampleIn, dacLevel;
  logic [1:0] gainSelect;
  int         n_mismatch = 0, checks = 0, n;
  hpps_top #(.STARTUP_CNT(SU), .TOUT_STEP(10), .RAMP_STEP(2)) i_dut (.clock, .rst,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .queueWrite, .queueData,
    .queueNak, .queueFull, .sourceEmpty, .playStart, .sampleValid, .sampleIn,
    .dacLevel, .boostEnable, .ampEnable, .gainSelect, .analogSelect, .overTemp,
    .brownout);
  hpps_queue_model i_queue (.clock, .rst, .queueWrite, .queueData, .stall,
    .queueFull, .sourceEmpty, .sampleValid, .sampleIn);
  always #5 clock = ~clock;
  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task automatic poll(input logic [2:0] s);
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (v[2:0] !== s && n < 100);
    cmp(8'(v[2:0]), 8'(s));
    if (v[2:0] !== s) finish_test();
  endtask : poll
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_CTRL);
    cmp(v, 8'h01);
    wr(OFS_QUEUE, 8'h33);
    #1 cmp(8'(queueWrite), 8'h00);
    wr(OFS_CTRL, 8'h00);
    poll(3'd1);
    wr(OFS_QUEUE, 8'h05);
    #1 cmp(8'(boostEnable), 8'h01);
    n = 0;
    while (playStart !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    cmp(8'(n >= SU - 2 && n <= SU + 2), 8'h01);
    if (n == 100) finish_test();
    stall = 1'b0;
    poll(3'd4);
    cmp(dacLevel, 8'h05);
    poll(3'd5);
    wr(OFS_QUEUE, 8'h07);
    #1 cmp(8'(queueWrite), 8'h00);
    poll(3'd1);
    cmp(dacLevel, 8'h00);
    cmp(8'(boostEnable), 8'h00);
    wr(OFS_START, 8'h01);
    poll(3'd2);
    wr(OFS_CTRL, 8'h01);
    poll(3'd0);
    stall = 1'b1;
    wr(OFS_CTRL, 8'h00);
    for (int i = 0; i < 5; i++)
      wr(OFS_QUEUE, 8'h10);
    #1 cmp(8'(queueNak), 8'h01);
    rd(OFS_STATUS);
    cmp(8'(v[STAT_NAK]), 8'h01);
    rd(OFS_STATUS);
    cmp(8'(v[STAT_NAK]), 8'h00);
    wr(OFS_CTRL, 8'h04);
    rd(OFS_CTRL);
    cmp(v, 8'h01);
    poll(3'd0);
    stall = 1'b0;
    for (int g = 0; g < 4; g++) begin
      wr(OFS_CTRL, 8'(g * 8 + 1));
      #1 cmp(8'(gainSelect), 8'(g));
    end
    wr(OFS_CTRL, 8'h9A);
    repeat (2) @(posedge clock);
    #1 cmp(8'(boostEnable), 8'h01);
    cmp(8'(analogSelect), 8'h01);
    @(posedge clock) overTemp <= 1'b1;
    repeat (8) @(posedge clock);
    #1 cmp(8'(boostEnable), 8'h00);
    @(posedge clock) overTemp <= 1'b0;
    repeat (8) @(posedge clock);
    #1 cmp(8'(boostEnable), 8'h01);
    @(posedge clock) brownout <= 1'b1;
    repeat (10) @(posedge clock);
    brownout <= 1'b0;
    #1 cmp(8'(boostEnable), 8'h00);
    repeat (6) @(posedge clock);
    rd(OFS_CTRL);
    cmp(v, 8'h01);
    finish_test();
  end
endmodule : hpps_top_test

// ===== src/hpps_pkg.sv
// Constants shared by the haptic power and playback sequencer.
// Assumes a 100 MHz core clock and a register port with one-cycle strobes.
package hpps_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_START  = 8'h04;
  localparam logic [7:0] OFS_QUEUE  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // Control, start and status field positions
  localparam int CTRL_STANDBY   = 0;
  localparam int CTRL_FORCE     = 1;
  localparam int CTRL_SOFTRST   = 2;
  localparam int CTRL_GAIN_LO   = 3;
  localparam int CTRL_TOUT_LO   = 5;
  localparam int CTRL_ANALOG    = 7;
  localparam int START_GO       = 0;
  localparam int STAT_NAK       = 4;

  // Reset values
  localparam logic       RST_STANDBY = 1'b1;
  localparam logic [1:0] RST_GAIN    = 2'h0;
  localparam logic [1:0] RST_TOUT    = 2'h0;
  localparam logic [7:0] MIDSCALE    = 8'h00;

  // Timing
  localparam int CLK_MHZ              = 100;
  localparam int STARTUP_TIME_US      = 2000;
  localparam int TIMEOUT_STEP_MS      = 5;
  localparam int STARTUP_CYCLES       = STARTUP_TIME_US * CLK_MHZ;
  localparam int TIMEOUT_STEP_CYCLES  = TIMEOUT_STEP_MS * 1000 * CLK_MHZ;
  localparam int RAMP_STEP_CYCLES     = 1000;
  localparam int CNT_W                = 24;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_IDLE    = 3'b001,
    ST_STARTUP = 3'b010,
    ST_PLAY    = 3'b011,
    ST_TIMEOUT = 3'b100,
    ST_RAMP    = 3'b101
  } hpps_state_t;

endpackage : hpps_pkg

// ===== src/hpps_top.sv
// Power state and playback start sequencer for a piezo haptic driver.
// Assumes a same-clock sample source and queue; temperature and brownout
// flags arrive asynchronously from analog circuits.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module hpps_top
  import hpps_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES,
  parameter int TOUT_STEP   = TIMEOUT_STEP_CYCLES,
  parameter int RAMP_STEP   = RAMP_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // Sample queue
  output logic            queueWrite,
  output logic      [7:0] queueData,
  output logic            queueNak,
  input  wire logic       queueFull,
  input  wire logic       sourceEmpty,
  // Playback engine
  output logic            playStart,
  input  wire logic       sampleValid,
  input  wire logic [7:0] sampleIn,
  output logic      [7:0] dacLevel,
  // Analog control
  output logic            boostEnable,
  output logic            ampEnable,
  output logic      [1:0] gainSelect,
  output logic            analogSelect,
  // Protection flags from analog
  input  wire logic       overTemp,
  input  wire logic       brownout
);

  // Synchronisers for asynchronous protection flags
  logic [2:0] tempSync;
  logic [2:0] brownSync;
  logic       tempHot;
  logic       brownLow;
  logic       next_tempHot;
  logic       next_brownLow;

  always_comb begin
    next_tempHot  = (tempSync[1] == tempSync[2]) ? tempSync[2] : tempHot;
    next_brownLow = (brownSync[1] == brownSync[2]) ? brownSync[2] : brownLow;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tempSync  <= 3'h0;
      brownSync <= 3'h0;
      tempHot   <= 1'b0;
      brownLow  <= 1'b0;
    end else begin
      tempSync  <= {tempSync[1:0], overTemp};
      brownSync <= {brownSync[1:0], brownout};
      tempHot   <= next_tempHot;
      brownLow  <= next_brownLow;
    end
  end

  // Control and sequencer state
  hpps_state_t      state;
  hpps_state_t      next_state;
  logic             standby;
  logic             alwaysOnForce;
  logic       [1:0] gain;
  logic       [1:0] toutSel;
  logic             analog;
  logic             nakFlag;
  logic [CNT_W-1:0] count;
  logic       [7:0] level;
  logic             next_standby;
  logic             next_alwaysOnForce;
  logic       [1:0] next_gain;
  logic       [1:0] next_toutSel;
  logic             next_analog;
  logic             next_nakFlag;
  logic [CNT_W-1:0] next_count;
  logic       [7:0] next_level;
  logic       [7:0] next_rdata;
  logic             next_qWrite;
  logic       [7:0] next_qData;
  logic             next_qNak;
  logic             next_playStart;
  logic             next_boost;
  logic             next_amp;

  logic             wrCtrl;
  logic             wrGo;
  logic             wrQueue;
  logic             softReset;
  logic             powered;
  logic [CNT_W-1:0] toutLimit;

  // Register address decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  // States in which the boost and amplifier must be up
  function automatic logic needs_power(input hpps_state_t st);
    case (st)
      ST_STARTUP, ST_PLAY, ST_TIMEOUT, ST_RAMP: begin
        needs_power = 1'b1;
      end
      default: begin
        needs_power = 1'b0;
      end
    endcase
  endfunction : needs_power

  // Idle timeout length in cycles
  function automatic logic [CNT_W-1:0] tout_cycles(input logic [1:0] sel);
    tout_cycles = CNT_W'((int'(sel) + 1) * TOUT_STEP);
  endfunction : tout_cycles

  // Next values for the port, control and sequencer
  always_comb begin
    wrCtrl         = regWrite && addr_hit(regAddr, OFS_CTRL);
    wrGo           = regWrite && addr_hit(regAddr, OFS_START) && regWdata[START_GO];
    wrQueue        = regWrite && addr_hit(regAddr, OFS_QUEUE);
    softReset      = wrCtrl && regWdata[CTRL_SOFTRST];
    toutLimit      = tout_cycles(toutSel);
    next_state     = state;
    next_standby   = standby;
    next_alwaysOnForce = alwaysOnForce;
    next_gain      = gain;
    next_toutSel   = toutSel;
    next_analog    = analog;
    next_nakFlag   = nakFlag;
    next_count     = count;
    next_level     = level;
    next_qWrite    = 1'b0;
    next_qData     = regWdata;
    next_qNak      = 1'b0;
    next_playStart = 1'b0;
    next_rdata     = 8'h00;

    // Register reads
    if (regRead) begin
      case (regAddr)
        OFS_CTRL: begin
          next_rdata = {analog, toutSel, gain, 1'b0, alwaysOnForce, standby};
        end
        OFS_STATUS: begin
          next_rdata = {1'b0, brownLow, tempHot, nakFlag, 1'b0, state};
          next_nakFlag = 1'b0;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end

    // Control writes
    if (wrCtrl) begin
      next_standby = regWdata[CTRL_STANDBY];
      next_alwaysOnForce = regWdata[CTRL_FORCE];
      next_gain    = regWdata[CTRL_GAIN_LO +: 2];
      next_toutSel = regWdata[CTRL_TOUT_LO +: 2];
      next_analog  = regWdata[CTRL_ANALOG];
    end

    // Sequencer
    case (state)
      ST_STANDBY: begin
        next_level = MIDSCALE;
        if (!standby) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wrQueue || wrGo || alwaysOnForce) begin
          next_state = ST_STARTUP;
          next_count = '0;
        end
      end
      ST_STARTUP: begin
        next_count = count + 1'b1;
        if (tempHot) begin
          next_count = '0;
        end else if (count >= CNT_W'(STARTUP_CNT - 1)) begin
          next_state     = ST_PLAY;
          next_playStart = 1'b1;
          next_count     = '0;
        end
      end
      ST_PLAY: begin
        if (sampleValid) begin
          next_level = sampleIn;
        end
        if (sourceEmpty && !wrQueue) begin
          next_state = ST_TIMEOUT;
          next_count = '0;
        end
      end
      ST_TIMEOUT: begin
        next_count = count + 1'b1;
        if (wrQueue || wrGo) begin
          next_state     = ST_PLAY;
          next_playStart = 1'b1;
        end else if (alwaysOnForce) begin
          next_count = '0;
        end else if (count >= toutLimit - 1'b1) begin
          next_count = '0;
          next_state = (level != MIDSCALE) ? ST_RAMP : ST_IDLE;
        end
      end
      ST_RAMP: begin
        next_count = count + 1'b1;
        if (level == MIDSCALE) begin
          next_state = ST_IDLE;
        end else if (count >= CNT_W'(RAMP_STEP - 1)) begin
          next_count = '0;
          next_level = level[7] ? level + 8'h01 : level - 8'h01;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase

    // Queue writes: dropped in standby or ramp, refused when full
    if (wrQueue && state != ST_STANDBY && state != ST_RAMP) begin
      if (queueFull) begin
        next_qNak    = 1'b1;
        next_nakFlag = 1'b1;
      end else begin
        next_qWrite = 1'b1;
      end
    end

    // Standby overrides every other mode
    if (next_standby) begin
      next_state     = ST_STANDBY;
      next_qWrite    = 1'b0;
      next_playStart = 1'b0;
    end
  end

  // Power enables follow the next sequencer state or the force bit, held off while hot
  always_comb begin
    powered    = needs_power(next_state) || (next_alwaysOnForce && !next_standby);
    next_boost = powered && !tempHot;
    next_amp   = powered && !tempHot;
  end

  // Control, sequencer and port registers
  always_ff @(posedge clock) begin
    if (rst || brownLow || softReset) begin
      state        <= ST_STANDBY;
      standby      <= RST_STANDBY;
      alwaysOnForce <= 1'b0;
      gain         <= RST_GAIN;
      toutSel      <= RST_TOUT;
      analog       <= 1'b0;
      nakFlag      <= 1'b0;
      count        <= '0;
      level        <= MIDSCALE;
      regRdata     <= 8'h00;
      queueWrite   <= 1'b0;
      queueData    <= 8'h00;
      queueNak     <= 1'b0;
      playStart    <= 1'b0;
      dacLevel     <= MIDSCALE;
      gainSelect   <= RST_GAIN;
      analogSelect <= 1'b0;
    end else begin
      state        <= next_state;
      standby      <= next_standby;
      alwaysOnForce <= next_alwaysOnForce;
      gain         <= next_gain;
      toutSel      <= next_toutSel;
      analog       <= next_analog;
      nakFlag      <= next_nakFlag;
      count        <= next_count;
      level        <= next_level;
      regRdata     <= next_rdata;
      queueWrite   <= next_qWrite;
      queueData    <= next_qData;
      queueNak     <= next_qNak;
      playStart    <= next_playStart;
      dacLevel     <= next_level;
      gainSelect   <= next_gain;
      analogSelect <= next_analog;
    end
  end

  // Power enable registers
  always_ff @(posedge clock) begin
    if (rst || brownLow || softReset) begin
      boostEnable <= 1'b0;
      ampEnable   <= 1'b0;
    end else begin
      boostEnable <= next_boost;
      ampEnable   <= next_amp;
    end
  end

endmodule : hpps_top
